// ==== logic/scsam_pkg.sv ====
// constants and carrier types for the speed command select and analog map block
//
// Behaviour
// - exactly one of four speed sources is used, picked by the source-select field.
// - select code 00b picks the analog speed-pin level.
// - in analog mode a level at or below the standby-entry level gives zero duty.
// - in analog mode from the standby-exit level to full scale duty rises linearly.
// - in analog mode a level above full scale clamps duty at 100%.
// - a top-speed limit of zero forces the speed reference to zero.
// - analog, pin-duty and pin-frequency sources only work as a standby device.
// - the serial speed word works both as a sleep device and as a standby device.
// - select code 01b picks the pin duty-cycle source.
// - select code 10b picks the serially written speed word.
// - select code 11b picks the pin frequency source.
package scsam_pkg;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned MULT_W = 24;
  localparam logic [DATA_W-1:0] DUTY_FULL = 12'hFFF;
  localparam logic [DATA_W-1:0] DUTY_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] DEF_ENTRY_LEVEL = 12'h0C0;
  localparam logic [DATA_W-1:0] DEF_EXIT_LEVEL = 12'h100;
  localparam logic [DATA_W-1:0] DEF_FULL_SCALE = 12'hE00;
  localparam logic [1:0] SEL_ANALOG = 2'h0;
  localparam logic [1:0] SEL_PIN_DUTY = 2'h1;
  localparam logic [1:0] SEL_SERIAL = 2'h2;
  localparam logic [1:0] SEL_PIN_FREQ = 2'h3;
  localparam logic DEV_STANDBY = 1'h0;
  localparam logic DEV_SLEEP = 1'h1;

  typedef enum logic [1:0] {
    SCSAM_SRC_ANALOG = 2'b00,
    SCSAM_SRC_PIN_DUTY = 2'b01,
    SCSAM_SRC_SERIAL = 2'b10,
    SCSAM_SRC_PIN_FREQ = 2'b11
  } scsam_src_type;

  typedef struct packed {
    logic [DATA_W-1:0] entry_level;
    logic [DATA_W-1:0] exit_level;
    logic [DATA_W-1:0] full_scale;
  } scsam_thresh_type;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] value;
  } scsam_sample_type;
endpackage

// ==== logic/scsam_analog_map.sv ====
// analog level to duty command map with standby band and full-scale clamp
module scsam_analog_map (
  // clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // conversion in
  input wire scsam_pkg::scsam_sample_type sample,
  input wire scsam_pkg::scsam_thresh_type thresh,
  // duty out
  output logic [scsam_pkg::DATA_W-1:0] duty_reg,
  output logic duty_valid_reg
);
  logic [scsam_pkg::DATA_W-1:0] span;
  logic [scsam_pkg::DATA_W-1:0] offs;
  logic [scsam_pkg::MULT_W-1:0] scaled;
  logic [scsam_pkg::DATA_W-1:0] duty_next;

  // span of one avoids a divide by zero on a bad threshold setting
  assign span = (thresh.full_scale > thresh.exit_level) ?
    scsam_pkg::DATA_W'(thresh.full_scale - thresh.exit_level) : 12'h001;
  assign offs = scsam_pkg::DATA_W'(sample.value - thresh.exit_level);
  assign scaled = (scsam_pkg::MULT_W'(offs) * scsam_pkg::MULT_W'(scsam_pkg::DUTY_FULL))
    / scsam_pkg::MULT_W'(span);

  always_comb begin
    if (sample.value <= thresh.entry_level) begin
      duty_next = scsam_pkg::DUTY_ZERO;
    end else if (sample.value > thresh.full_scale) begin
      duty_next = scsam_pkg::DUTY_FULL;
    end else if (sample.value < thresh.exit_level) begin
      // hysteresis gap between entry and exit stays stopped
      duty_next = scsam_pkg::DUTY_ZERO;
    end else begin
      duty_next = scaled[scsam_pkg::DATA_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      duty_reg <= scsam_pkg::DUTY_ZERO;
      duty_valid_reg <= 1'h0;
    end else if (clk_en) begin
      duty_valid_reg <= sample.valid;
      if (sample.valid) begin
        duty_reg <= duty_next;
      end
    end
  end

  a_update_one_cycle: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && sample.valid && sample.value > thresh.full_scale
      |=> duty_reg == scsam_pkg::DUTY_FULL)
    else $error("clamp not applied one cycle after sample");
  a_low_band_zero: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && sample.valid && sample.value <= thresh.entry_level
      |=> duty_reg == scsam_pkg::DUTY_ZERO && duty_valid_reg)
    else $error("duty not zero below entry level");
  a_linear_bounded: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && sample.valid && sample.value >= thresh.exit_level
      && sample.value <= thresh.full_scale && thresh.full_scale > thresh.exit_level
      |=> duty_reg == scsam_pkg::DATA_W'($past(scaled)))
    else $error("duty not linear in active band");
endmodule

// ==== logic/scsam_top.sv ====
// speed command source selection with analog map and top-speed limit
module scsam_top (
  // clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // configuration
  input wire logic [1:0] source_select,
  input wire logic sleep_capable_select,
  input wire logic [scsam_pkg::DATA_W-1:0] top_speed_limit,
  input wire logic [scsam_pkg::DATA_W-1:0] standby_entry_level,
  input wire logic [scsam_pkg::DATA_W-1:0] standby_exit_level,
  input wire logic [scsam_pkg::DATA_W-1:0] analog_full_scale_level,
  // analog converter
  input wire logic adc_valid,
  input wire logic [scsam_pkg::DATA_W-1:0] adc_level,
  // other sources, already mapped to duty
  input wire logic [scsam_pkg::DATA_W-1:0] pin_duty_cmd,
  input wire logic [scsam_pkg::DATA_W-1:0] pin_freq_cmd,
  input wire logic [scsam_pkg::DATA_W-1:0] serial_speed_word,
  // results
  output logic [scsam_pkg::DATA_W-1:0] duty_cmd_reg,
  output logic [scsam_pkg::DATA_W-1:0] speed_ref_reg,
  output logic source_ok_reg
);
  scsam_pkg::scsam_sample_type sample;
  scsam_pkg::scsam_thresh_type thresh;
  scsam_pkg::scsam_src_type src;
  logic [scsam_pkg::DATA_W-1:0] analog_duty;
  logic analog_valid;
  logic [scsam_pkg::DATA_W-1:0] duty_cmd_next;
  logic [scsam_pkg::DATA_W-1:0] speed_ref_next;
  logic source_ok_next;

  assign sample = '{valid: adc_valid, value: adc_level};
  assign thresh = '{entry_level: standby_entry_level, exit_level: standby_exit_level,
    full_scale: analog_full_scale_level};
  assign src = scsam_pkg::scsam_src_type'(source_select);

  scsam_analog_map u_map (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .sample(sample),
    .thresh(thresh),
    .duty_reg(analog_duty),
    .duty_valid_reg(analog_valid)
  );

  // pin sources are refused on a sleep device; only the serial word works there
  always_comb begin
    duty_cmd_next = scsam_pkg::DUTY_ZERO;
    source_ok_next = 1'h0;
    unique case (src)
      scsam_pkg::SCSAM_SRC_ANALOG: begin
        source_ok_next = (sleep_capable_select == scsam_pkg::DEV_STANDBY);
        if (source_ok_next) duty_cmd_next = analog_duty;
      end
      scsam_pkg::SCSAM_SRC_PIN_DUTY: begin
        source_ok_next = (sleep_capable_select == scsam_pkg::DEV_STANDBY);
        if (source_ok_next) duty_cmd_next = pin_duty_cmd;
      end
      scsam_pkg::SCSAM_SRC_SERIAL: begin
        source_ok_next = 1'h1;
        duty_cmd_next = serial_speed_word;
      end
      scsam_pkg::SCSAM_SRC_PIN_FREQ: begin
        source_ok_next = (sleep_capable_select == scsam_pkg::DEV_STANDBY);
        if (source_ok_next) duty_cmd_next = pin_freq_cmd;
      end
    endcase
  end

  // reference follows duty up to top_speed_limit; a zero limit stops it whatever the duty says
  always_comb begin
    if (top_speed_limit == scsam_pkg::DUTY_ZERO) begin
      speed_ref_next = scsam_pkg::DUTY_ZERO;
    end else if (duty_cmd_next > top_speed_limit) begin
      speed_ref_next = top_speed_limit;
    end else begin
      speed_ref_next = duty_cmd_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      duty_cmd_reg <= scsam_pkg::DUTY_ZERO;
      source_ok_reg <= 1'h0;
    end else if (clk_en) begin
      duty_cmd_reg <= duty_cmd_next;
      source_ok_reg <= source_ok_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speed_ref_reg <= scsam_pkg::DUTY_ZERO;
    end else if (clk_en) begin
      speed_ref_reg <= speed_ref_next;
    end
  end

  sequence s_pin_source_on_sleep;
    clk_en && sleep_capable_select == scsam_pkg::DEV_SLEEP
      && source_select != scsam_pkg::SEL_SERIAL;
  endsequence
  sequence s_serial_selected;
    clk_en && source_select == scsam_pkg::SEL_SERIAL;
  endsequence

  a_limit_zero_stop: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && top_speed_limit == scsam_pkg::DUTY_ZERO |=> speed_ref_reg == scsam_pkg::DUTY_ZERO)
    else $error("speed reference not zero with zero limit");
  a_sleep_refuses_pin: assert property (@(posedge sys_clk) disable iff (srst)
    s_pin_source_on_sleep |=> !source_ok_reg && duty_cmd_reg == scsam_pkg::DUTY_ZERO)
    else $error("pin source accepted on sleep device");
  a_serial_always_ok: assert property (@(posedge sys_clk) disable iff (srst)
    s_serial_selected |=> source_ok_reg && duty_cmd_reg == $past(serial_speed_word))
    else $error("serial word not taken");
  a_analog_pick: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && source_select == scsam_pkg::SEL_ANALOG && !sleep_capable_select
      |=> duty_cmd_reg == $past(analog_duty))
    else $error("analog duty not selected");
  a_pin_duty_pick: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && source_select == scsam_pkg::SEL_PIN_DUTY && !sleep_capable_select
      |=> duty_cmd_reg == $past(pin_duty_cmd))
    else $error("pin duty not selected");
  a_pin_freq_pick: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && source_select == scsam_pkg::SEL_PIN_FREQ && !sleep_capable_select
      |=> duty_cmd_reg == $past(pin_freq_cmd))
    else $error("pin frequency not selected");
  a_ref_never_above: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en |=> speed_ref_reg <= duty_cmd_reg)
    else $error("speed reference above duty command");

  // analog path seen from the pins: map at the sample edge, select one edge later
  sequence s_analog_sample_low;
    clk_en && adc_valid && adc_level <= standby_entry_level;
  endsequence
  sequence s_analog_sample_gap;
    clk_en && adc_valid && adc_level > standby_entry_level
      && adc_level < standby_exit_level
      && adc_level <= analog_full_scale_level;
  endsequence
  sequence s_analog_sample_exit;
    clk_en && adc_valid && adc_level == standby_exit_level
      && standby_exit_level <= analog_full_scale_level;
  endsequence
  sequence s_analog_sample_full;
    clk_en && adc_valid && adc_level == analog_full_scale_level
      && analog_full_scale_level > standby_exit_level
      && analog_full_scale_level > standby_entry_level;
  endsequence
  sequence s_analog_sample_high;
    clk_en && adc_valid && adc_level > analog_full_scale_level
      && adc_level > standby_entry_level;
  endsequence
  sequence s_analog_in_use;
    clk_en && source_select == scsam_pkg::SEL_ANALOG
      && sleep_capable_select == scsam_pkg::DEV_STANDBY;
  endsequence
  a_analog_stop_path: assert property (@(posedge sys_clk) disable iff (srst)
    s_analog_sample_low ##1 s_analog_in_use |=> duty_cmd_reg == scsam_pkg::DUTY_ZERO)
    else $error("analog duty not zero two cycles after a low sample");
  a_analog_gap_path: assert property (@(posedge sys_clk) disable iff (srst)
    s_analog_sample_gap ##1 s_analog_in_use |=> duty_cmd_reg == scsam_pkg::DUTY_ZERO)
    else $error("analog duty not zero inside the standby band");
  a_analog_exit_path: assert property (@(posedge sys_clk) disable iff (srst)
    s_analog_sample_exit ##1 s_analog_in_use |=> duty_cmd_reg == scsam_pkg::DUTY_ZERO)
    else $error("analog duty not zero at the bottom of the linear band");
  a_analog_full_path: assert property (@(posedge sys_clk) disable iff (srst)
    s_analog_sample_full ##1 s_analog_in_use |=> duty_cmd_reg == scsam_pkg::DUTY_FULL)
    else $error("analog duty not full at the top of the linear band");
  a_analog_clamp_path: assert property (@(posedge sys_clk) disable iff (srst)
    s_analog_sample_high ##1 s_analog_in_use |=> duty_cmd_reg == scsam_pkg::DUTY_FULL)
    else $error("analog duty not clamped two cycles after a high sample");
  a_map_valid_step: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en |=> analog_valid == $past(adc_valid))
    else $error("conversion not marked one cycle after it arrived");
  a_map_holds: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && !adc_valid |=> $stable(analog_duty))
    else $error("analog duty moved without a new conversion");

  // a low enable must hold every output, whatever the other inputs do; srst still clears them
  a_freeze_outputs: assert property (@(posedge sys_clk) disable iff (srst)
    !clk_en |=> $stable(duty_cmd_reg) && $stable(speed_ref_reg) && $stable(source_ok_reg))
    else $error("outputs moved while the clock enable was low");
  a_freeze_map: assert property (@(posedge sys_clk) disable iff (srst)
    !clk_en |=> $stable(analog_duty) && $stable(analog_valid))
    else $error("analog map moved while the clock enable was low");
  a_reset_clears: assert property (@(posedge sys_clk)
    srst |=> duty_cmd_reg == scsam_pkg::DUTY_ZERO && speed_ref_reg == scsam_pkg::DUTY_ZERO
      && !source_ok_reg)
    else $error("outputs not cleared by reset");

  // a non-zero limit caps the reference; below it the reference follows the duty
  a_ref_capped: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && top_speed_limit != scsam_pkg::DUTY_ZERO && duty_cmd_next > top_speed_limit
      |=> speed_ref_reg == $past(top_speed_limit))
    else $error("speed reference not capped at the limit");
  a_ref_follows_duty: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && top_speed_limit != scsam_pkg::DUTY_ZERO && duty_cmd_next <= top_speed_limit
      |=> speed_ref_reg == duty_cmd_reg)
    else $error("speed reference not equal to duty below the limit");

  // device-mode gating as seen at the outputs
  a_single_source: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en |=> duty_cmd_reg == scsam_pkg::DUTY_ZERO || duty_cmd_reg == $past(analog_duty)
      || duty_cmd_reg == $past(pin_duty_cmd) || duty_cmd_reg == $past(pin_freq_cmd)
      || duty_cmd_reg == $past(serial_speed_word))
    else $error("duty command from no known source");
  a_standby_accepts: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && sleep_capable_select == scsam_pkg::DEV_STANDBY |=> source_ok_reg)
    else $error("source refused on a standby device");
  a_sleep_serial_ok: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && sleep_capable_select == scsam_pkg::DEV_SLEEP
      && source_select == scsam_pkg::SEL_SERIAL |=> source_ok_reg)
    else $error("serial word refused on a sleep device");
  a_refused_stops_ref: assert property (@(posedge sys_clk) disable iff (srst)
    s_pin_source_on_sleep |=> speed_ref_reg == scsam_pkg::DUTY_ZERO)
    else $error("speed reference not zero for a refused source");
  a_refused_zero_duty: assert property (@(posedge sys_clk) disable iff (srst)
    !source_ok_reg |-> duty_cmd_reg == scsam_pkg::DUTY_ZERO)
    else $error("duty command not zero while the source is refused");
endmodule

// ==== testbench/scsam_source_model.sv ====
// behavioural speed source delivering converted speed-pin levels
module scsam_source_model #(
  parameter int WAIT_CYC = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // converter side
  output logic adc_valid,
  output logic [scsam_pkg::DATA_W-1:0] adc_level,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    adc_valid = 1'h0;
    adc_level = 12'hA5A;
  end
  // scaled stand-in for the settling wait after power-up
  always @(posedge sys_clk) begin
    if (srst) cnt <= 0;
    else if (cnt < WAIT_CYC) cnt <= cnt + 1;
  end
  assign ready = (cnt >= WAIT_CYC);
  // level is scrambled after the pulse so nothing reads a stale sample
  task automatic convert(input logic [scsam_pkg::DATA_W-1:0] lvl);
    @(negedge sys_clk);
    adc_valid = 1'h1;
    adc_level = lvl;
    @(negedge sys_clk);
    adc_valid = 1'h0;
    adc_level = ~lvl;
  endtask
endmodule

// ==== testbench/scsam_top_tb.sv ====
// self-checking bench for the speed command select block
module scsam_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, srst = 1'h1, clk_en = 1'h1, sleep_capable_select = 1'h0, adc_valid;
  logic ready, source_ok_reg;
  logic [1:0] source_select = scsam_pkg::SEL_SERIAL;
  logic [11:0] top_speed_limit = 12'hFFF, pin_duty_cmd = 12'h111, pin_freq_cmd = 12'h333;
  logic [11:0] serial_speed_word = 12'h222, adc_level, duty_cmd_reg, speed_ref_reg;
  int n_errors = 0, samples_checked = 0;
  always #10 sys_clk = ~sys_clk;
  scsam_top scsam_top_i (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .source_select(source_select), .sleep_capable_select(sleep_capable_select),
    .top_speed_limit(top_speed_limit), .standby_entry_level(scsam_pkg::DEF_ENTRY_LEVEL),
    .standby_exit_level(scsam_pkg::DEF_EXIT_LEVEL),
    .analog_full_scale_level(scsam_pkg::DEF_FULL_SCALE), .adc_valid(adc_valid),
    .adc_level(adc_level), .pin_duty_cmd(pin_duty_cmd), .pin_freq_cmd(pin_freq_cmd),
    .serial_speed_word(serial_speed_word), .duty_cmd_reg(duty_cmd_reg),
    .speed_ref_reg(speed_ref_reg), .source_ok_reg(source_ok_reg));
  scsam_source_model scsam_source_model_i (.sys_clk(sys_clk), .srst(srst),
    .adc_valid(adc_valid), .adc_level(adc_level), .ready(ready));
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [11:0] amap(input int lvl);
    int ex, fs;
    ex = int'(scsam_pkg::DEF_EXIT_LEVEL);
    fs = int'(scsam_pkg::DEF_FULL_SCALE);
    if (lvl <= int'(scsam_pkg::DEF_ENTRY_LEVEL) || lvl < ex) return 12'h000;
    if (lvl > fs) return scsam_pkg::DUTY_FULL;
    return 12'((lvl - ex) * int'(scsam_pkg::DUTY_FULL) / (fs - ex));
  endfunction
  task automatic test_analog;
    logic [11:0] lv [8] = '{12'h000, 12'h0C0, 12'h0E0, 12'h100, 12'h800, 12'hDFF, 12'hE00,
      12'hE01};
    source_select = scsam_pkg::SEL_ANALOG;
    foreach (lv[i]) begin
      scsam_source_model_i.convert(lv[i]);
      step(1);
      chk("analog duty", duty_cmd_reg, amap(int'(lv[i])));
      chk("analog speed ref", speed_ref_reg, amap(int'(lv[i])));
    end
    step(3);
    chk("analog duty held", duty_cmd_reg, 12'hFFF);
  endtask
  task automatic test_limit;
    top_speed_limit = 12'h000;
    step(1);
    chk("zero limit speed ref", speed_ref_reg, 12'h000);
    chk("zero limit duty", duty_cmd_reg, 12'hFFF);
    top_speed_limit = 12'h400;
    step(1);
    chk("capped speed ref", speed_ref_reg, 12'h400);
    top_speed_limit = 12'hFFF;
  endtask
  task automatic test_sources;
    logic [11:0] val [4] = '{12'hFFF, 12'h111, 12'h222, 12'h333};
    logic ok;
    for (int d = 0; d < 2; d++) begin
      for (int s = 0; s < 4; s++) begin
        sleep_capable_select = d[0];
        source_select = s[1:0];
        ok = (d == 0) || (s == 2);
        step(1);
        chk("src duty", duty_cmd_reg, ok ? val[s] : 12'h000);
        chk("source ok", {11'h000, source_ok_reg}, {11'h000, ok});
      end
    end
    sleep_capable_select = 1'h0;
  endtask
  task automatic test_freeze_reset;
    source_select = scsam_pkg::SEL_SERIAL;
    step(1);
    clk_en = 1'h0;
    serial_speed_word = 12'h5A5;
    step(3);
    chk("frozen duty", duty_cmd_reg, 12'h222);
    clk_en = 1'h1;
    step(1);
    chk("serial duty", duty_cmd_reg, 12'h5A5);
    srst = 1'h1;
    step(1);
    chk("reset duty", duty_cmd_reg, 12'h000);
    chk("reset speed ref", speed_ref_reg, 12'h000);
    srst = 1'h0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    step(4);
    chk("reset duty", duty_cmd_reg, 12'h000);
    srst = 1'h0;
    while (!ready) step(1);
    test_analog();
    test_limit();
    test_sources();
    test_freeze_reset();
    finish_test();
  end
  initial begin
    #40000;
    n_errors++;
    finish_test();
  end
endmodule
